/* flash_bus_pkg.sv */
/*
  Constants for the parallel flash bus host: pin codes, autoselect codes,
  bus timing counts and request kinds.
  Assumes a 20 MHz clock and an asynchronous NOR flash on the far side.
*/
package flash_bus_pkg;
  localparam int ClkPeriodNs = 50;
  localparam int ReadAccessNs = 90;
  localparam int WritePulseNs = 50;
  localparam int RecoverNs = 50;
  localparam int ResetPulseNs = 500;
  localparam int ReadCycles = (ReadAccessNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int WriteCycles = (WritePulseNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int RecoverCycles = (RecoverNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int ResetCycles = (ResetPulseNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int CountW = 5;
  localparam int AddrW = 21;
  localparam int DataW = 16;
  localparam int ByteW = 8;
  // Pin level codes for the protect/accelerate and reset pins
  localparam logic [1:0] LevelLow = 2'h0;
  localparam logic [1:0] LevelHigh = 2'h1;
  localparam logic [1:0] LevelElevated = 2'h2;
  // Autoselect address bits A1/A0 and the answer codes
  localparam int AselA0 = 0;
  localparam int AselA1 = 1;
  localparam logic [7:0] ProtYes = 8'h01;
  localparam logic [7:0] ProtNo = 8'h00;
  localparam logic [7:0] SecLocked = 8'h99;
  localparam logic [7:0] SecOpen = 8'h19;
  localparam int SecLockBit = 7;
  localparam int ProtBit = 0;
  typedef enum logic [1:0] {ReqRead, ReqWrite, ReqAccelWrite, ReqReset} req_kind_e;
endpackage

/* flash_cycle_timer.sv */
/*
  Down counter that times one phase of a flash bus cycle.
  Assumes the caller loads it only when it is idle.
*/
`timescale 1ns/10ps
module flash_cycle_timer
  import flash_bus_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [flash_bus_pkg::CountW-1:0] loadValue,
  output logic done
);
  logic [CountW-1:0] count_reg;
  logic [CountW-1:0] count_next;

  assign count_next = load ? loadValue : (count_reg != '0 ? count_reg - 1'b1 : count_reg);
  // Done from the count alone: the caller's load depends on done
  assign done = (count_reg == '0);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end
endmodule

/* flash_bus_host.sv */
/*
  Host controller that drives an asynchronous parallel NOR flash through its
  pins: read, command write, accelerated write, hardware reset, autoselect
  decode of returned codes, and byte/word addressing.
  Assumes the flash pins are sampled synchronous to clk.
*/
`timescale 1ns/10ps
module flash_bus_host
  import flash_bus_pkg::*;
#(
  parameter int AddrWidth = flash_bus_pkg::AddrW,
  parameter int DataWidth = flash_bus_pkg::DataW
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire flash_bus_pkg::req_kind_e reqKind,
  input wire logic [AddrWidth-1:0] reqAddr,
  input wire logic [DataWidth-1:0] reqData,
  input wire logic reqByteMode,
  input wire logic reqLowByteHigh,
  input wire logic reqUnprotect,
  output logic rspValid,
  output logic [DataWidth-1:0] rspData,
  output logic rspProtected,
  output logic rspSecLocked,
  output logic chipEnable_n,
  output logic outputEnable_n,
  output logic writeStrobe_n,
  output logic [1:0] resetLevel,
  output logic [1:0] protectAccelLevel,
  output logic byteMode_n,
  output logic [AddrWidth-1:0] addrOut,
  input wire logic [DataWidth-1:0] dataIn,
  output logic [DataWidth-1:0] dataOut,
  output logic dataOe_n
);
  import flash_bus_pkg::*;

  typedef enum logic [2:0] {Idle, ReadWait, WriteHold, ResetHold, Recover} state_e;

  state_e state_reg;
  state_e state_next;
  req_kind_e kind_reg;
  logic [AddrWidth-1:0] addr_reg;
  logic [DataWidth-1:0] wdata_reg;
  logic byte_reg;
  logic lowHigh_reg;
  logic unprot_reg;
  logic [DataWidth-1:0] rspData_reg;
  logic rspValid_reg;
  logic rspProt_reg;
  logic rspSec_reg;
  logic timerLoad;
  logic [CountW-1:0] timerValue;
  logic timerDone;
  logic accept;
  logic inRead;
  logic inWrite;
  logic inReset;
  logic [DataWidth-1:0] capData;

  // Byte mode keeps only the low data byte; word mode takes all lines
  function automatic logic [DataWidth-1:0] lane_pick(input logic [DataWidth-1:0] d,
                                                     input logic byteSel);
    lane_pick = byteSel ? {{(DataWidth-ByteW){1'b0}}, d[ByteW-1:0]} : d;
  endfunction

  assign accept = reqValid && (state_reg == Idle);
  assign reqReady = (state_reg == Idle);
  assign inRead = (state_reg == ReadWait);
  assign inWrite = (state_reg == WriteHold);
  assign inReset = (state_reg == ResetHold);
  assign capData = lane_pick(dataIn, byte_reg);

  flash_cycle_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  always_comb
  begin
    state_next = state_reg;
    timerLoad = 1'b0;
    timerValue = '0;
    case (state_reg)
      Idle:
        if (accept)
        begin
          timerLoad = 1'b1;
          case (reqKind)
            ReqRead:
            begin
              state_next = ReadWait;
              timerValue = CountW'(ReadCycles);
            end
            ReqWrite, ReqAccelWrite:
            begin
              state_next = WriteHold;
              timerValue = CountW'(WriteCycles);
            end
            default:
            begin
              state_next = ResetHold;
              timerValue = CountW'(ResetCycles);
            end
          endcase
        end
      ReadWait, WriteHold, ResetHold:
        if (timerDone)
        begin
          state_next = Recover;
          timerLoad = 1'b1;
          timerValue = CountW'(RecoverCycles);
        end
      Recover:
        if (timerDone)
          state_next = Idle;
      default:
        state_next = Idle;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= Idle;
      kind_reg <= ReqRead;
      addr_reg <= '0;
      wdata_reg <= '0;
      byte_reg <= 1'b0;
      lowHigh_reg <= 1'b0;
      unprot_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (accept)
      begin
        kind_reg <= reqKind;
        addr_reg <= reqAddr;
        wdata_reg <= reqData;
        byte_reg <= reqByteMode;
        lowHigh_reg <= reqLowByteHigh;
        unprot_reg <= reqUnprotect;
      end
    end
  end

  // Answer captured at the end of the access time, one-cycle pulse
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rspValid_reg <= 1'b0;
      rspData_reg <= '0;
      rspProt_reg <= 1'b0;
      rspSec_reg <= 1'b0;
    end
    else
    begin
      rspValid_reg <= inRead && timerDone;
      if (inRead && timerDone)
      begin
        rspData_reg <= capData;
        rspProt_reg <= capData[ProtBit];
        rspSec_reg <= capData[SecLockBit];
      end
    end
  end

  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;
  assign rspProtected = rspProt_reg;
  assign rspSecLocked = rspSec_reg;

  // Strobes are combinational decodes of the state register, not separately registered flops
  assign chipEnable_n = !(inRead || inWrite);
  assign outputEnable_n = !inRead;
  assign writeStrobe_n = !inWrite;
  assign resetLevel = inReset ? LevelLow : (unprot_reg ? LevelElevated : LevelHigh);
  // Elevated only inside an accelerated write; otherwise the pin risks damage
  assign protectAccelLevel = (inWrite && kind_reg == ReqAccelWrite) ? LevelElevated
                             : LevelHigh;
  assign byteMode_n = !byte_reg;
  assign addrOut = addr_reg;
  // In byte mode Q15 carries the lowest address bit
  assign dataOut = (inRead && byte_reg) ? {lowHigh_reg, {(DataWidth-1){1'b0}}}
                   : (byte_reg ? {lowHigh_reg, {(DataWidth-ByteW-1){1'b0}},
                                  wdata_reg[ByteW-1:0]} : wdata_reg);
  // Bus driven on writes, and all lines on byte-mode reads to put the bit on Q15 (the flash floats it)
  assign dataOe_n = !(inWrite || (inRead && byte_reg));

  strobe_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(!outputEnable_n && !writeStrobe_n))
    else $error("Output enable and write strobe both low");
  write_ce_a: assert property (@(posedge clk) disable iff (!rst_n)
    !writeStrobe_n |-> (!chipEnable_n && outputEnable_n && !dataOe_n))
    else $error("Write strobe without chip enable or bus drive");
  accel_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (protectAccelLevel == LevelElevated) |-> (!writeStrobe_n && kind_reg == ReqAccelWrite))
    else $error("Accelerate level outside accelerated write");
  read_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(inRead)) |-> inRead [*2] ##[1:4] rspValid)
    else $error("Read cycle length wrong");
  reset_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (resetLevel == LevelLow) |-> (chipEnable_n && outputEnable_n && writeStrobe_n))
    else $error("Bus cycle during hardware reset");
  byte_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!outputEnable_n && byteMode_n == 1'b0) |-> (dataOut[DataWidth-1] == lowHigh_reg))
    else $error("Q15 not carrying low address bit");
  prot_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    rspValid |-> (rspProtected == rspData[ProtBit] && rspSecLocked == rspData[SecLockBit]))
    else $error("Autoselect flags disagree with data");
  ready_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    reqReady |-> (chipEnable_n && writeStrobe_n))
    else $error("Ready while a cycle is active");
endmodule

/* flash_device_model.sv */
/*
  Behavioural parallel NOR flash: array read, command writes, autoselect
  codes, byte mode, sector lock and the reset pin levels.
  Assumes the host's pins change only on clk edges; clk is used for sampling only.
*/
`timescale 1ns/10ps
module flash_device_model
  import flash_bus_pkg::*;
#(
  parameter logic [7:0] MakerCode = 8'h5a, // Arbitrary value
  parameter logic [7:0] PartCode = 8'h3c, // Arbitrary value
  parameter logic [7:0] AselCmd = 8'h90,
  parameter logic [7:0] ProgCmd = 8'ha0,
  parameter logic [7:0] EraseCmd = 8'h80,
  parameter logic [7:0] SectorEraseCmd = 8'h30,
  parameter logic [7:0] ChipEraseCmd = 8'h10,
  parameter logic [8:0] LockedSector = 9'h005,
  parameter logic FactoryLocked = 1'b1
)
(
  input wire logic clk,
  input wire logic chipEnable_n,
  input wire logic outputEnable_n,
  input wire logic writeStrobe_n,
  input wire logic [1:0] resetLevel,
  input wire logic [1:0] protectAccelLevel,
  input wire logic byteMode_n,
  input wire logic [20:0] addrOut,
  input wire logic [15:0] dataOut,
  input wire logic dataOe_n,
  output logic [15:0] dataIn
);
  logic [15:0] mem [0:255];
  logic aselReg = 1'b0;
  logic progReg = 1'b0;
  logic eraseReg = 1'b0;
  logic wasWriting = 1'b0;
  logic wLock;
  logic [7:0] wAddr;
  logic [15:0] wData, word, lastDrv = '0;
  logic [7:0] aselByte;
  wire inReset = resetLevel == LevelLow;
  // Host not driving: the lines float, shown as the inverse of the last value
  wire [15:0] busIn = dataOe_n ? ~lastDrv : dataOut;
  wire selected = !chipEnable_n && !inReset;
  wire writing = selected && !writeStrobe_n && outputEnable_n;
  wire driving = selected && !outputEnable_n && writeStrobe_n;
  wire sectorLocked = addrOut[20:12] == LockedSector;
  wire lockedNow = sectorLocked || (protectAccelLevel == LevelLow && addrOut[20:13] == 8'h00);
  initial
    for (int i = 0; i < 256; i++)
      mem[i] = {8'(i), ~8'(i)};
  always_comb
  begin
    case (addrOut[1:0])
      2'h0: aselByte = MakerCode;
      2'h1: aselByte = PartCode;
      2'h2: aselByte = sectorLocked ? ProtYes : ProtNo;
      default: aselByte = FactoryLocked ? SecLocked : SecOpen;
    endcase
    word = aselReg ? {~lastDrv[15:8], aselByte} : mem[addrOut[7:0]];
    // Released lines show a changing pattern, never the last value
    if (!driving)
      dataIn = ~lastDrv;
    else if (byteMode_n)
      dataIn = word;
    else
      dataIn = {~lastDrv[15:8], busIn[15] ? word[15:8] : word[7:0]};
  end
  always @(posedge clk)
  begin
    lastDrv <= dataIn;
    wasWriting <= writing;
    if (writing)
    begin
      wAddr <= addrOut[7:0];
      wData <= busIn;
      wLock <= lockedNow;
    end
    if (inReset)
    begin
      aselReg <= 1'b0;
      progReg <= 1'b0;
      eraseReg <= 1'b0;
    end
    else if (wasWriting && !writing)
    begin
      aselReg <= !progReg && !eraseReg && wData[7:0] == AselCmd;
      progReg <= !progReg && !aselReg && !eraseReg && wData[7:0] == ProgCmd;
      eraseReg <= !progReg && !aselReg && !eraseReg && wData[7:0] == EraseCmd;
      if (progReg && (!wLock || resetLevel == LevelElevated))
        mem[wAddr] <= wData;
      // One small window stands for every sector, so an erase clears all of it
      if (eraseReg && (wData[7:0] == ChipEraseCmd || (wData[7:0] == SectorEraseCmd
          && (!wLock || resetLevel == LevelElevated))))
        for (int i = 0; i < 256; i++)
          mem[i] <= '1;
    end
  end
endmodule

/* tb.sv */
/*
  Self-checking bench: flash bus host against the flash model.
  Assumes the package, the host and the model only.
*/
`timescale 1ns/10ps
module tb;
  import flash_bus_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic reqValid = 0;
  req_kind_e reqKind = ReqRead;
  logic [20:0] reqAddr = '0;
  logic [15:0] reqData = '0;
  logic reqByteMode = 0, reqLowByteHigh = 0, reqUnprotect = 0;
  logic reqReady, rspValid, rspProtected, rspSecLocked;
  logic chipEnable_n, outputEnable_n, writeStrobe_n, byteMode_n, dataOe_n;
  logic [1:0] resetLevel, protectAccelLevel;
  logic [20:0] addrOut;
  logic [15:0] rspData, dataIn, dataOut;
  int n_fail = 0, num_checks = 0;
  always #25 clk = ~clk;
  flash_bus_host u_flash_bus_host (.clk, .rst_n, .reqValid, .reqReady, .reqKind, .reqAddr,
    .reqData, .reqByteMode, .reqLowByteHigh, .reqUnprotect, .rspValid, .rspData, .rspProtected,
    .rspSecLocked, .chipEnable_n, .outputEnable_n, .writeStrobe_n, .resetLevel,
    .protectAccelLevel, .byteMode_n, .addrOut, .dataIn, .dataOut, .dataOe_n);
  flash_device_model u_flash_device_model (.clk, .chipEnable_n, .outputEnable_n,
    .writeStrobe_n, .resetLevel, .protectAccelLevel, .byteMode_n, .addrOut, .dataOut, .dataOe_n,
    .dataIn);
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic issue(req_kind_e k, logic [20:0] a, logic [15:0] d = 0, logic bm = 0,
    logic lb = 0);
    int n = 0;
    @(posedge clk);
    reqValid <= 1;
    reqKind <= k;
    reqAddr <= a;
    reqData <= d;
    reqByteMode <= bm;
    reqLowByteHigh <= lb;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (reqReady !== 1'b1 && n < 100);
    if (reqReady !== 1'b1)
      chk("ready", 16'h1, 16'h0);
    if (reqReady !== 1'b1)
      complete_run();
    @(posedge clk);
    reqValid <= 0;
  endtask
  task automatic rd(string what, logic [20:0] a, logic [15:0] e, logic bm = 0, logic lb = 0);
    int n = 0;
    issue(ReqRead, a, 16'h0, bm, lb);
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rspValid !== 1'b1 && n < 20);
    // Access count, one capture edge, then seen at the following falling edge
    chk("latency", 16'(ReadCycles + 2), 16'(n));
    chk(what, e, rspData);
    if (rspValid !== 1'b1)
      complete_run();
  endtask
  task automatic test_power_up();
    rd("array", 21'h000012, 16'h12ed);
    rd("byte low", 21'h000012, 16'h00ed, 1, 0);
    rd("byte high", 21'h000012, 16'h0012, 1, 1);
    $display("power up test done");
  endtask
  task automatic test_autoselect();
    issue(ReqWrite, 21'h000555, 16'h0090);
    rd("maker", 21'h000000, 16'h005a, 1);
    rd("part", 21'h000001, 16'h003c, 1);
    rd("prot yes", 21'h005002, 16'h0001, 1);
    chk("prot flag", 16'h1, 16'(rspProtected));
    rd("prot no", 21'h000402, 16'h0000, 1);
    rd("security", 21'h000003, 16'h0099, 1);
    chk("lock flag", 16'h1, 16'(rspSecLocked));
    issue(ReqWrite, 21'h000000, 16'h00f0);
    rd("array again", 21'h000003, 16'h03fc);
    $display("autoselect test done");
  endtask
  task automatic test_abort();
    issue(ReqWrite, 21'h000555, 16'h0090);
    issue(ReqWrite, 21'h000555, 16'h0077);
    rd("after bad write", 21'h000001, 16'h01fe);
    issue(ReqWrite, 21'h000555, 16'h0090);
    issue(ReqReset, 21'h000000);
    rd("after reset", 21'h000001, 16'h01fe);
    $display("abort test done");
  endtask
  task automatic test_program();
    issue(ReqWrite, 21'h000555, 16'h00a0);
    issue(ReqAccelWrite, 21'h000040, 16'hbeef);
    rd("programmed", 21'h000040, 16'hbeef);
    issue(ReqWrite, 21'h000555, 16'h00a0);
    issue(ReqWrite, 21'h000041, 16'hcafe);
    rd("normal program", 21'h000041, 16'hcafe);
    issue(ReqWrite, 21'h000555, 16'h00a0);
    issue(ReqWrite, 21'h005034, 16'h1111);
    rd("locked", 21'h005034, 16'h34cb);
    @(posedge clk);
    reqUnprotect <= 1;
    issue(ReqWrite, 21'h000555, 16'h00a0);
    issue(ReqWrite, 21'h005034, 16'h1111);
    rd("unlocked", 21'h005034, 16'h1111);
    @(posedge clk);
    reqUnprotect <= 0;
    $display("program test done");
  endtask
  task automatic test_erase();
    issue(ReqWrite, 21'h000555, 16'h0080);
    issue(ReqWrite, 21'h005000, 16'h0030);
    rd("erase locked", 21'h000041, 16'hcafe);
    issue(ReqWrite, 21'h000555, 16'h0080);
    issue(ReqWrite, 21'h001000, 16'h0030);
    rd("erase sector", 21'h000041, 16'hffff);
    $display("erase test done");
  endtask
  always @(negedge clk)
    if (rst_n)
    begin
      chk("strobes", 16'h1, 16'(outputEnable_n | writeStrobe_n));
      chk("accel", 16'h0, 16'(protectAccelLevel == LevelElevated && !outputEnable_n));
    end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    test_power_up();
    test_autoselect();
    test_abort();
    test_program();
    test_erase();
    complete_run();
  end
endmodule
